// *** hdl/sac_adc_ctrl.sv ***
// successive-approximation converter control with AXI4-Lite registers
// Function
// - only software enable starts conversions
// - back-to-back conversions, done request each end
// - three-bit field selects one of six inputs
// - time code selects conversion length in clocks
// - mode bit 7 enables; byte writes accepted
// - resolve MSB first, transfer after LSB
// - result loaded each end, byte readable
// - result register not reset
// - reset clears mode and channel registers
// - sample four steps of the selected length, then hold until done
// - first step sets bit 7, half scale
// - each step tries next bit, keeps on compare
// - after bit 0, latch and request together
// - mode or channel write aborts, restarts
// - coinciding read gets old result first
// - coinciding write wins, no load, no request
// - mode write leaves done flag alone
`timescale 1ns/1ps
module sac_adc_ctrl
   import sac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output wire logic        s_axi_wready,
   output wire logic [1:0]  s_axi_bresp,
   output wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output wire logic        s_axi_arready,
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0]  s_axi_rresp,
   output wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        compIn,
   output wire logic [2:0]  chanSel,
   output wire logic [7:0]  tapCode,
   output wire logic        sampleEn,
   output wire logic        holdEn,
   output wire logic        doneIrq
);
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   logic [1:0]  rresp_r;
   logic [31:0] rdata_r;
   logic        awHeld_r;
   logic        wHeld_r;
   logic [15:0] wrAddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic [7:0]  modeReg_r;
   logic [7:0]  chanReg_r;
   logic [7:0]  resultReg_r;
   logic        doneFlag_r;
   sac_state_t  state_r;
   logic [7:0]  sar_r;
   logic [2:0]  bitIdx_r;
   logic [1:0]  sampleCnt_r;
   logic        sampleEn_r;
   logic        holdEn_r;
   logic        doneIrq_r;
   logic [7:0]  convCnt_r;
   logic        wrFire;
   logic        modeWr;
   logic        chanWr;
   logic        statusClr;
   logic        abortWr;
   logic [7:0]  modeNxt;
   logic        compSync;
   logic        convEnd;
   logic [7:0]  sarDecided;
   logic [31:0] rdMux;

   sac_pace_if pace ();

   function automatic logic isMapped(input logic [15:0] addr);
      isMapped = (addr == OFF_MODE) || (addr == OFF_CHAN) ||
                 (addr == OFF_RESULT) || (addr == OFF_STATUS);
   endfunction

   sac_sync2 u_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .asyncIn (compIn),
      .syncOut (compSync)
   );

   sac_step_timer u_timer
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .pace    (pace.ctrl)
   );

   assign wrFire    = awHeld_r && wHeld_r && !bvalid_r;
   assign modeWr    = wrFire && wrAddr_r == OFF_MODE && wstrb_r[0];
   assign chanWr    = wrFire && wrAddr_r == OFF_CHAN && wstrb_r[0];
   assign statusClr = wrFire && wrAddr_r == OFF_STATUS && wstrb_r[0] &&
                      wdata_r[STAT_DONE_BIT];
   assign abortWr   = modeWr || chanWr;
   assign modeNxt   = modeWr ? (wdata_r[7:0] & MODE_WMASK) : modeReg_r;
   // step length from incoming code
   // a mode write reloads the timer, so it must see the new code
   assign pace.stepLen = stepCycles(modeNxt[TIME_LSB +: 3]);
   assign pace.restart = abortWr;
   assign convEnd   = state_r == ST_COMPARE && pace.stepEnd &&
                      bitIdx_r == 3'h0;
   // keep bit when input at or above tap
   assign sarDecided = compSync ? sar_r : (sar_r & ~bitMask(bitIdx_r));

   // write address and data are taken in either order
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         awHeld_r  <= 1'b0;
         wHeld_r   <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         wrAddr_r  <= 16'h0000;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end
      else if (clk_en)
      begin
         if (!awHeld_r && !bvalid_r)
            awready_r <= 1'b1;
         if (!wHeld_r && !bvalid_r)
            wready_r <= 1'b1;
         if (s_axi_awvalid && awready_r)
         begin
            awready_r <= 1'b0;
            awHeld_r  <= 1'b1;
            wrAddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r)
         begin
            wready_r <= 1'b0;
            wHeld_r  <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wrFire)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= isMapped(wrAddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
         end
      end
   end

   always_comb
   begin
      rdMux = 32'h0000_0000;
      case (s_axi_araddr)
         OFF_MODE:   rdMux[7:0] = modeReg_r;
         OFF_CHAN:   rdMux[7:0] = chanReg_r;
         OFF_RESULT: rdMux[7:0] = resultReg_r;
         OFF_STATUS:
         begin
            rdMux[STAT_DONE_BIT] = doneFlag_r;
            rdMux[STAT_BUSY_BIT] = state_r != ST_IDLE;
         end
         default:    rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (!rvalid_r)
            arready_r <= 1'b1;
         if (s_axi_arvalid && arready_r)
         begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rdMux;
            rresp_r   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         modeReg_r <= MODE_RESET;
         chanReg_r <= CHAN_RESET;
      end
      else if (clk_en)
      begin
         modeReg_r <= modeNxt;
         if (chanWr)
            chanReg_r <= wdata_r[7:0] & CHAN_WMASK;
      end
   end

   always_ff @(posedge clk)
   begin
      if (clk_en && convEnd && !abortWr)
         resultReg_r <= sarDecided;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         doneFlag_r <= 1'b0;
      else if (clk_en)
      begin
         if (convEnd && !abortWr)
            doneFlag_r <= 1'b1;
         else if (statusClr)
            doneFlag_r <= 1'b0;
      end
   end

   // sequencer: four sample steps then eight compare steps
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_r     <= ST_IDLE;
         sar_r       <= SAR_CLEAR;
         bitIdx_r    <= MSB_IDX;
         sampleCnt_r <= 2'h0;
         sampleEn_r  <= 1'b0;
         holdEn_r    <= 1'b0;
         doneIrq_r   <= 1'b0;
      end
      else if (clk_en)
      begin
         doneIrq_r <= 1'b0;
         if (abortWr)
         begin
            state_r     <= modeNxt[MODE_EN_BIT] ? ST_SAMPLE : ST_IDLE;
            sampleEn_r  <= modeNxt[MODE_EN_BIT];
            holdEn_r    <= 1'b0;
            sar_r       <= SAR_CLEAR;
            bitIdx_r    <= MSB_IDX;
            sampleCnt_r <= 2'h0;
         end
         else
         begin
            case (state_r)
               ST_SAMPLE:
               begin
                  if (pace.stepEnd)
                  begin
                     if (sampleCnt_r == SAMPLE_LAST)
                     begin
                        state_r    <= ST_COMPARE;
                        sampleEn_r <= 1'b0;
                        holdEn_r   <= 1'b1;
                        sar_r      <= bitMask(MSB_IDX);
                        bitIdx_r   <= MSB_IDX;
                     end
                     else
                        sampleCnt_r <= sampleCnt_r + 2'h1;
                  end
               end
               ST_COMPARE:
               begin
                  if (pace.stepEnd)
                  begin
                     if (bitIdx_r == 3'h0)
                     begin
                        doneIrq_r   <= 1'b1;
                        state_r     <= ST_SAMPLE;
                        sampleEn_r  <= 1'b1;
                        holdEn_r    <= 1'b0;
                        sampleCnt_r <= 2'h0;
                        sar_r       <= SAR_CLEAR;
                     end
                     else
                     begin
                        sar_r    <= sarDecided | bitMask(bitIdx_r - 3'h1);
                        bitIdx_r <= bitIdx_r - 3'h1;
                     end
                  end
               end
               default:
                  state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // conversion clock counter, read by the checks below
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         convCnt_r <= 8'h00;
      else if (clk_en)
      begin
         if (abortWr || convEnd)
            convCnt_r <= 8'h00;
         else
            convCnt_r <= convCnt_r + 8'h01;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign chanSel       = chanReg_r[2:0];
   assign tapCode       = sar_r;
   assign sampleEn      = sampleEn_r;
   assign holdEn        = holdEn_r;
   assign doneIrq       = doneIrq_r;

   property p_idle_stays;
      @(posedge clk) disable iff (sys_rst)
      (state_r == ST_IDLE && !abortWr) |=> state_r == ST_IDLE;
   endproperty
   a_idle_stays: assert property (p_idle_stays)
      else $error("left idle without an enabling write");

   property p_back_to_back;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && convEnd && !abortWr) |=>
         doneIrq_r && state_r == ST_SAMPLE && sampleEn_r;
   endproperty
   a_back_to_back: assert property (p_back_to_back)
      else $error("no done request or restart after conversion");

   property p_chan_write;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && chanWr) |=> chanReg_r == {5'h00, $past(wdata_r[2:0])};
   endproperty
   a_chan_write: assert property (p_chan_write)
      else $error("channel field not stored");

   property p_conv_len;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && convEnd && !abortWr) |->
         convCnt_r == 8'(pace.stepLen) * STEPS_PER_CONV - 8'h01;
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion length differs from selected time");

   property p_enable_bit;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && modeWr) |=> modeReg_r[MODE_EN_BIT] == $past(wdata_r[7]);
   endproperty
   a_enable_bit: assert property (p_enable_bit)
      else $error("enable bit not taken from write");

   property p_result_load;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && convEnd && !abortWr) |=>
         resultReg_r == $past(sarDecided) && doneIrq_r;
   endproperty
   a_result_load: assert property (p_result_load)
      else $error("result not latched with done request");

   property p_reset_clear;
      @(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> modeReg_r == MODE_RESET && chanReg_r == CHAN_RESET;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("control registers not cleared by reset");

   property p_hold;
      @(posedge clk) disable iff (sys_rst)
      state_r == ST_COMPARE |-> holdEn_r && !sampleEn_r;
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold not kept while comparing");

   property p_msb_first;
      @(posedge clk) disable iff (sys_rst)
      (state_r == ST_COMPARE && $past(state_r) == ST_SAMPLE) |->
         sar_r == 8'h80 && bitIdx_r == 3'h7;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("first step does not try bit 7");

   property p_step;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && state_r == ST_COMPARE && pace.stepEnd &&
       bitIdx_r != 3'h0 && !abortWr) |=>
         sar_r == ($past(sarDecided) | bitMask($past(bitIdx_r) - 3'h1));
   endproperty
   a_step: assert property (p_step)
      else $error("step did not keep decision and try next bit");

   property p_abort;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && abortWr) |=> convCnt_r == 8'h00 && sar_r == SAR_CLEAR &&
         !doneIrq_r && (state_r == ST_SAMPLE) == $past(modeNxt[7]);
   endproperty
   a_abort: assert property (p_abort)
      else $error("register write did not abort and restart");

   property p_write_wins;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && abortWr && convEnd) |=> $stable(resultReg_r);
   endproperty
   a_write_wins: assert property (p_write_wins)
      else $error("result loaded despite coinciding write");

   property p_flag_keep;
      @(posedge clk) disable iff (sys_rst)
      (doneFlag_r && !statusClr) |=> doneFlag_r;
   endproperty
   a_flag_keep: assert property (p_flag_keep)
      else $error("done flag lost without a clear");

   c_conv_end: cover property (@(posedge clk) disable iff (sys_rst)
      clk_en && convEnd && !abortWr);
   c_abort_cmp: cover property (@(posedge clk) disable iff (sys_rst)
      clk_en && abortWr && state_r == ST_COMPARE);
   c_read_at_end: cover property (@(posedge clk) disable iff (sys_rst)
      clk_en && convEnd && s_axi_arvalid && arready_r &&
      s_axi_araddr == OFF_RESULT);
endmodule

// *** shared/sac_pkg.sv ***
// constants, types and decoders shared by the converter control files
package sac_pkg;
   localparam logic [15:0] OFF_MODE       = 16'hff80;
   localparam logic [15:0] OFF_CHAN       = 16'hff84;
   localparam logic [15:0] OFF_RESULT     = 16'hff88;
   localparam logic [15:0] OFF_STATUS     = 16'hff8c;
   localparam logic [7:0]  MODE_RESET     = 8'h00;
   localparam logic [7:0]  CHAN_RESET     = 8'h00;
   localparam logic [7:0]  MODE_WMASK     = 8'hb8;
   localparam logic [7:0]  CHAN_WMASK     = 8'h07;
   localparam int          MODE_EN_BIT    = 7;
   localparam int          TIME_LSB       = 3;
   localparam int          STAT_DONE_BIT  = 0;
   localparam int          STAT_BUSY_BIT  = 1;
   localparam logic [1:0]  SAMPLE_LAST    = 2'h3;
   localparam logic [7:0]  STEPS_PER_CONV = 8'h0c;
   localparam logic [3:0]  STEP_144       = 4'hc;
   localparam logic [3:0]  STEP_120       = 4'ha;
   localparam logic [3:0]  STEP_96        = 4'h8;
   localparam logic [3:0]  STEP_72        = 4'h6;
   localparam logic [3:0]  STEP_60        = 4'h5;
   localparam logic [3:0]  STEP_48        = 4'h4;
   localparam logic [2:0]  MSB_IDX        = 3'h7;
   localparam logic [7:0]  SAR_CLEAR      = 8'h00;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_COMPARE} sac_state_t;

   // clocks per step; a conversion is twelve steps
   function automatic logic [3:0] stepCycles(input logic [2:0] code);
      case (code)
         3'h0: stepCycles = STEP_144;
         3'h1: stepCycles = STEP_120;
         3'h2: stepCycles = STEP_96;
         3'h4: stepCycles = STEP_72;
         3'h5: stepCycles = STEP_60;
         3'h6: stepCycles = STEP_48;
         default: stepCycles = STEP_144;
      endcase
   endfunction

   function automatic logic [7:0] bitMask(input logic [2:0] idx);
      bitMask = 8'h01 << idx;
   endfunction
endpackage

// *** shared/sac_pace_if.sv ***
// pacing link between the sequencer and its step timer
`timescale 1ns/1ps
interface sac_pace_if;
   logic       restart;
   logic [3:0] stepLen;
   logic       stepEnd;
   modport ctrl  (output restart, output stepLen, input stepEnd);
   modport timer (input restart, input stepLen, output stepEnd);
endinterface

// *** hdl/sac_sync2.sv ***
// two-stage synchroniser for the comparator decision
`timescale 1ns/1ps
module sac_sync2
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic asyncIn,
   output wire logic syncOut
);
   logic meta_r;
   logic stable_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_r   <= 1'b0;
         stable_r <= 1'b0;
      end
      else if (clk_en)
      begin
         meta_r   <= asyncIn;
         stable_r <= meta_r;
      end
   end

   assign syncOut = stable_r;
endmodule

// *** hdl/sac_step_timer.sv ***
// step timer: one stepEnd every stepLen enabled clocks
`timescale 1ns/1ps
module sac_step_timer
   import sac_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   sac_pace_if.timer pace
);
   logic [3:0] cnt_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cnt_r <= 4'h0;
      else if (clk_en)
      begin
         if (pace.restart || cnt_r == 4'h0)
            cnt_r <= pace.stepLen - 4'h1;
         else
            cnt_r <= cnt_r - 4'h1;
      end
   end

   assign pace.stepEnd = (cnt_r == 4'h0);
endmodule

// *** verification/sac_comp_model.sv ***
// comparator, sample-hold and ladder model on the converter's analog side
`timescale 1ns/1ps
module sac_comp_model
(
   input  wire logic        clk,
   input  wire logic [47:0] levels,
   input  wire logic [2:0]  chanSel,
   input  wire logic [7:0]  tapCode,
   input  wire logic        sampleEn,
   input  wire logic        holdEn,
   output wire logic        compIn
);
   logic [7:0] held = 8'h00;
   logic       junk = 1'b0;
   // track the input while sampling; codes above five read ground
   always @(posedge clk)
   begin
      junk <= ~junk;
      if (sampleEn)
         held <= (chanSel < 3'h6) ? levels[chanSel*8 +: 8] : 8'h00;
   end
   // outside hold the decision means nothing, so it toggles
   assign compIn = holdEn ? (held >= tapCode) : junk;
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
   import sac_pkg::*;
   typedef struct packed
   {
      logic [15:0] a;
      logic [3:0]  s;
      logic [7:0]  d;
      logic [7:0]  e;
      logic [1:0]  r;
   } sac_row_t;
   logic        clk = 1'b0;
   logic        sysRst = 1'b1;
   logic        clkEn = 1'b1;
   logic [15:0] awaddr = 16'h0000;
   logic [15:0] araddr = 16'h0000;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic [47:0] levels = {8'h5a, 8'h01, 8'h80, 8'h7f, 8'hff, 8'h00};
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [2:0]  chanSel;
   logic [7:0]  tapCode;
   logic        compIn, sampleEn, holdEn, doneIrq;
   int          badCount = 0;
   int          totalChecks = 0;
   int          n;
   logic [2:0]  codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   int          lens [4] = '{144, 120, 96, 72};
   // channel bits 3-7 written as zero
   // mode bits 0-2 and 6 written as zero
   sac_row_t    rows [6] = '{
      '{OFF_MODE, 4'h1, 8'h20, 8'h20, RESP_OKAY},
      '{OFF_MODE, 4'h0, 8'h80, 8'h20, RESP_OKAY},
      '{OFF_MODE, 4'h1, 8'h00, 8'h00, RESP_OKAY},
      '{OFF_CHAN, 4'h1, 8'h05, 8'h05, RESP_OKAY},
      '{OFF_CHAN, 4'h1, 8'h02, 8'h02, RESP_OKAY},
      '{16'hff90, 4'h1, 8'h55, 8'h00, RESP_SLVERR}};

   always #20 clk = ~clk;

   sac_adc_ctrl sac_adc_ctrl_i
   (
      .clk           (clk),
      .sys_rst       (sysRst),
      .clk_en        (clkEn),
      .s_axi_awaddr  (awaddr),
      .s_axi_awvalid (awvalid),
      .s_axi_awready (awready),
      .s_axi_wdata   (wdata),
      .s_axi_wstrb   (wstrb),
      .s_axi_wvalid  (wvalid),
      .s_axi_wready  (wready),
      .s_axi_bresp   (bresp),
      .s_axi_bvalid  (bvalid),
      .s_axi_bready  (1'b1),
      .s_axi_araddr  (araddr),
      .s_axi_arvalid (arvalid),
      .s_axi_arready (arready),
      .s_axi_rdata   (rdata),
      .s_axi_rresp   (rresp),
      .s_axi_rvalid  (rvalid),
      .s_axi_rready  (1'b1),
      .compIn        (compIn),
      .chanSel       (chanSel),
      .tapCode       (tapCode),
      .sampleEn      (sampleEn),
      .holdEn        (holdEn),
      .doneIrq       (doneIrq)
   );

   sac_comp_model sac_comp_model_i
   (
      .clk      (clk),
      .levels   (levels),
      .chanSel  (chanSel),
      .tapCode  (tapCode),
      .sampleEn (sampleEn),
      .holdEn   (holdEn),
      .compIn   (compIn)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         badCount++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ready lines are held high, so only the valids are released
   task automatic wr(input logic [15:0] a, input logic [7:0] v,
                     input logic [3:0] s, output logic [1:0] rs);
      int k;
      k = 0;
      awaddr <= a;
      wdata <= {24'h000000, v};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && k < 50);
      rs = bresp;
      if (k >= 50)
         badCount++;
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      int k;
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && k < 50);
      v = rdata;
      rs = rresp;
      if (k >= 50)
         badCount++;
   endtask

   // edges until a done pulse is seen, capped at 400
   task automatic waitDone(output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (doneIrq !== 1'b1 && k < 400);
   endtask

   task automatic stopTest;
      $display("checks %0d errors %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      badCount++;
      stopTest();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
      rd(OFF_MODE, d, r);
      chk(d, 32'h0);
      rd(OFF_CHAN, d, r);
      chk(d, 32'h0);
      chk({29'h0, chanSel}, 32'h0);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d, rows[i].s, r);
         chk({30'h0, r}, {30'h0, rows[i].r});
         rd(rows[i].a, d, r);
         chk(d, {24'h0, rows[i].e});
         chk({30'h0, r}, {30'h0, rows[i].r});
      end
      // only codes of at least 2.88 microseconds
      for (int i = 0; i < 6; i++)
      begin
         wr(OFF_CHAN, 8'(i), 4'h1, r);
         wr(OFF_MODE, {2'h2, codes[i % 4], 3'h0}, 4'h1, r);
         // first result after enabling is dropped
         waitDone(n);
         waitDone(n);
         chk(n, lens[i % 4]);
         // result only read while still enabled
         rd(OFF_RESULT, d, r);
         chk(d, {24'h0, levels[i*8 +: 8]});
         chk({29'h0, chanSel}, 32'(i));
      end
      rd(OFF_STATUS, d, r);
      chk(d, 32'h3);
      wr(OFF_MODE, 8'h00, 4'h1, r);
      rd(OFF_STATUS, d, r);
      chk(d, 32'h1);
      wr(OFF_STATUS, 8'h01, 4'h1, r);
      rd(OFF_STATUS, d, r);
      chk(d, 32'h0);
      waitDone(n);
      chk(n, 400);
      chk({31'h0, sampleEn}, 32'h0);
      wr(OFF_MODE, 8'ha0, 4'h1, r);
      waitDone(n);
      repeat (30) @(posedge clk);
      wr(OFF_CHAN, 8'h03, 4'h1, r);
      waitDone(n);
      chk({31'h0, n > 60 && n < 76}, 32'h1);
      // clock enable low freezes the conversion just begun
      clkEn <= 1'b0;
      waitDone(n);
      chk(n, 400);
      clkEn <= 1'b1;
      // one enabled clock ran before the freeze took hold
      waitDone(n);
      chk(n, 72);
      stopTest();
   end
endmodule
